// >>> hdl/fpra_debounce.sv
// Purpose: two-flop synchroniser and stability filter for a push-button
// Assumes: raw is high while the button is pressed
// Notes: rise is one cycle wide, once per accepted press
`timescale 1ns/1ns
module fpra_debounce #(
	parameter int unsigned CYC = 50000
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic raw,
	output logic level,
	output logic rise
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic lvl;
		logic rise;
		logic [31:0] cnt;
	} fpra_deb_st_t;
	fpra_deb_st_t q_r, q_nxt;

	if (CYC < 1)
	begin : g_chk
		$error("fpra_debounce: CYC must be at least 1");
	end

	always_comb
	begin
		q_nxt = q_r;
		q_nxt.s1 = raw;
		q_nxt.s2 = q_r.s1;
		q_nxt.rise = 1'b0;
		if (q_r.s2 == q_r.lvl)
			q_nxt.cnt = '0;
		else if (q_r.cnt >= 32'(CYC - 1))
		begin
			q_nxt.cnt = '0;
			q_nxt.lvl = q_r.s2;
			q_nxt.rise = q_r.s2;
		end
		else
			q_nxt.cnt = q_r.cnt + 32'h1;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
			q_r <= '0;
		else
			q_r <= q_nxt;
	end

	assign level = q_r.lvl;
	assign rise = q_r.rise;

	// edge only when the synchronised input was high and the level low the cycle before
	a_deb_edge: assert property (@(posedge sys_clk) disable iff (!nrst)
		rise |-> $past(q_r.s2) && !$past(q_r.lvl))
		else $error("press accepted without stable input");
endmodule

// >>> hdl/fpra_params.svh
// Purpose: constants for the front panel reset, abort and lamp block
// Assumes: 10 MHz system clock
// Notes: times kept in their own units, cycle counts derived from them, except the local reset count given in cycles
`ifndef FPRA_PARAMS_SVH
`define FPRA_PARAMS_SVH
`define FPRA_CLK_HZ 10000000
`define FPRA_SYSRST_MS 200
`define FPRA_SYSRST_CYC (`FPRA_CLK_HZ / 1000 * `FPRA_SYSRST_MS)
`define FPRA_LOCRST_CYC 16
`define FPRA_DEB_US 5000
`define FPRA_DEB_CYC (`FPRA_CLK_HZ / 1000000 * `FPRA_DEB_US)
`define FPRA_BAUD 9600
`define FPRA_BAUD_DIV (`FPRA_CLK_HZ / (16 * `FPRA_BAUD))
`define FPRA_DATA_BITS 4'h8
`define FPRA_STOP_BITS 2'h1
`define FPRA_OFF_CTRL 8'h00
`define FPRA_OFF_STAT 8'h04
`define FPRA_OFF_SFMT 8'h08
`define FPRA_CTRL_EN 0
`define FPRA_CTRL_LVL_LO 1
`define FPRA_CTRL_LVL_HI 3
`define FPRA_CTRL_SYSRST 4
`define FPRA_CTRL_HOLD 5
`define FPRA_STAT_ABT 0
`define FPRA_STAT_PEND 1
`define FPRA_STAT_SYSCTL 2
`define FPRA_STAT_SYSACT 3
`define FPRA_STAT_LOCACT 4
`define FPRA_SFMT_DIV_HI 15
`define FPRA_SFMT_BITS_LO 16
`define FPRA_SFMT_STOP_LO 20
`define FPRA_SFMT_PARITY 22
`define FPRA_SFMT_SYNC 23
`define FPRA_SFMT_DTE 24
`define FPRA_PIN_WDOG 0
`define FPRA_PIN_VMERST 1
`define FPRA_PIN_SYSCTL 2
`define FPRA_PIN_BFAIL 3
`define FPRA_PIN_DBB 4
`define FPRA_PIN_GNT1 5
`define FPRA_PIN_GNT2 6
`define FPRA_PIN_CARRIER 7
`endif

// >>> hdl/fpra_pkg.sv
// Purpose: types shared by the front panel block
// Assumes: APB with 8-bit byte address and 32-bit data
// Notes: module state structs live in their own modules, not here
package fpra_pkg;
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} fpra_apb_req_t;
	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} fpra_apb_rsp_t;
	typedef struct packed {
		logic board_failure_lamp;
		logic cpu_lamp;
		logic slot_one_activity_lamp;
		logic slot_two_activity_lamp;
	} fpra_lamps_t;
	typedef enum logic [3:0] {
		FPRA_REG_CTRL = 4'h1,
		FPRA_REG_STAT = 4'h2,
		FPRA_REG_SFMT = 4'h4,
		FPRA_REG_NONE = 4'h8
	} fpra_reg_t;
endpackage

// >>> hdl/fpra_reset_hold.sv
// Purpose: stretches a reset trigger to a least assertion time
// Assumes: trig is a level from logic on sys_clk
// Notes: active stays for CYC cycles after trig last seen
`timescale 1ns/1ns
module fpra_reset_hold #(
	parameter int unsigned CYC = 2000000
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic trig,
	output logic active
);
	typedef struct packed {
		logic act;
		logic [31:0] cnt;
	} fpra_hold_st_t;
	fpra_hold_st_t q_r, q_nxt;

	if (CYC < 1)
	begin : g_chk
		$error("fpra_reset_hold: CYC must be at least 1");
	end

	always_comb
	begin
		q_nxt = q_r;
		// restart the hold on every trigger
		if (trig)
		begin
			q_nxt.act = 1'b1;
			q_nxt.cnt = 32'(CYC - 1);
		end
		else if (q_r.cnt != '0)
		begin
			q_nxt.act = 1'b1;
			q_nxt.cnt = q_r.cnt - 32'h1;
		end
		else
			q_nxt.act = 1'b0;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
			q_r <= '0;
		else
			q_r <= q_nxt;
	end

	assign active = q_r.act;
endmodule

// >>> hdl/fpra_top.sv
// Purpose: front panel abort interrupt, reset distribution and lamps
// Assumes: APB slave, one wait state; pins arrive asynchronously
// Notes: power-up reset is the release of nrst
//
// The APB interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`include "fpra_params.svh"
module fpra_top #(
	parameter int unsigned DEB_CYC = `FPRA_DEB_CYC,
	parameter int unsigned SYSRST_CYC = `FPRA_SYSRST_CYC,
	parameter int unsigned LOCRST_CYC = `FPRA_LOCRST_CYC
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input fpra_pkg::fpra_apb_req_t apb_req,
	output fpra_pkg::fpra_apb_rsp_t apb_rsp,
	input wire logic abort_button_n,
	input wire logic reset_button_n,
	input wire logic watchdog_timeout,
	input wire logic vme_sysreset_in_n,
	input wire logic system_controller,
	input wire logic expansion_carrier,
	input wire logic board_failure_n,
	input wire logic processor_data_bus_busy_n,
	input wire logic pci_gnt1_n,
	input wire logic pci_gnt2_n,
	output logic abort_irq8_n,
	output logic [2:0] abort_irq_level,
	output logic processor_hard_reset_n,
	output logic board_reset_n,
	output logic vme_sysreset_out,
	output logic vme_sysreset_oe,
	output fpra_pkg::fpra_lamps_t lamps,
	output logic [15:0] serial_baud_div
);
	import fpra_pkg::*;

	typedef struct packed {
		logic [7:0] s1;
		logic [7:0] s2;
		logic por;
		logic irq_en;
		logic [2:0] irq_lvl;
		logic hold;
		logic sys_req;
		logic pend;
		logic [15:0] baud;
		fpra_apb_rsp_t rsp;
		logic irq_n;
		logic hrst_n;
		logic brd_n;
		logic sys_oe;
		fpra_lamps_t lamps;
	} fpra_top_st_t;

	localparam fpra_top_st_t RST_ST = '{
		s1: 8'h00, s2: 8'h00, por: 1'b1, irq_en: 1'b0, irq_lvl: 3'h0,
		hold: 1'b0, sys_req: 1'b0, pend: 1'b0,
		baud: 16'(`FPRA_BAUD_DIV), rsp: '0, irq_n: 1'b1, hrst_n: 1'b0,
		brd_n: 1'b0, sys_oe: 1'b0, lamps: '0};

	fpra_top_st_t q_r, q_nxt, rst_ld;
	logic abt_lvl, abt_rise, rst_lvl, rst_rise;
	logic sys_act, loc_act;
	logic sys_trig, loc_trig, in_reset;

	if (SYSRST_CYC < 1 || LOCRST_CYC < 1 || DEB_CYC < 1)
	begin : g_chk
		$error("fpra_top: hold and filter counts must be at least 1");
	end

	function automatic fpra_reg_t decode(input logic [7:0] a);
		unique case (a)
			`FPRA_OFF_CTRL: decode = FPRA_REG_CTRL;
			`FPRA_OFF_STAT: decode = FPRA_REG_STAT;
			`FPRA_OFF_SFMT: decode = FPRA_REG_SFMT;
			default: decode = FPRA_REG_NONE;
		endcase
	endfunction

	fpra_debounce #(.CYC(DEB_CYC)) u_abt (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.raw(!abort_button_n),
		.level(abt_lvl),
		.rise(abt_rise)
	);
	fpra_debounce #(.CYC(DEB_CYC)) u_rst (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.raw(!reset_button_n),
		.level(rst_lvl),
		.rise(rst_rise)
	);

	fpra_reset_hold #(.CYC(SYSRST_CYC)) u_sys (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.trig(sys_trig),
		.active(sys_act)
	);
	fpra_reset_hold #(.CYC(LOCRST_CYC)) u_loc (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.trig(loc_trig),
		.active(loc_act)
	);

	always_comb
	begin
		sys_trig = q_r.s2[`FPRA_PIN_SYSCTL] & (rst_lvl | q_r.por
			| q_r.s2[`FPRA_PIN_WDOG] | q_r.sys_req);
		loc_trig = rst_lvl | q_r.por | q_r.s2[`FPRA_PIN_WDOG]
			| !q_r.s2[`FPRA_PIN_VMERST] | q_r.sys_req;
		in_reset = loc_act | q_r.hold;
	end

	always_comb
	begin
		q_nxt = q_r;
		q_nxt.s1 = {expansion_carrier, pci_gnt2_n, pci_gnt1_n,
			processor_data_bus_busy_n, board_failure_n, system_controller,
			vme_sysreset_in_n, watchdog_timeout};
		q_nxt.s2 = q_r.s1;
		q_nxt.por = 1'b0;
		q_nxt.sys_req = 1'b0;

		// APB: pready one cycle into the access phase
		if (apb_req.psel && apb_req.penable && !q_r.rsp.pready)
		begin
			q_nxt.rsp.pready = 1'b1;
			q_nxt.rsp.pslverr = 1'b0;
			q_nxt.rsp.prdata = '0;
			unique case (decode(apb_req.paddr))
				FPRA_REG_CTRL:
				begin
					q_nxt.rsp.prdata[`FPRA_CTRL_EN] = q_r.irq_en;
					q_nxt.rsp.prdata[`FPRA_CTRL_LVL_HI:`FPRA_CTRL_LVL_LO] =
						q_r.irq_lvl;
					q_nxt.rsp.prdata[`FPRA_CTRL_HOLD] = q_r.hold;
				end
				FPRA_REG_STAT:
				begin
					q_nxt.rsp.prdata[`FPRA_STAT_ABT] = abt_lvl;
					q_nxt.rsp.prdata[`FPRA_STAT_PEND] = q_r.pend;
					q_nxt.rsp.prdata[`FPRA_STAT_SYSCTL] =
						q_r.s2[`FPRA_PIN_SYSCTL];
					q_nxt.rsp.prdata[`FPRA_STAT_SYSACT] = sys_act;
					q_nxt.rsp.prdata[`FPRA_STAT_LOCACT] = loc_act;
				end
				FPRA_REG_SFMT:
				begin
					q_nxt.rsp.prdata[`FPRA_SFMT_DIV_HI:0] = q_r.baud;
					q_nxt.rsp.prdata[`FPRA_SFMT_BITS_LO +: 4] =
						`FPRA_DATA_BITS;
					q_nxt.rsp.prdata[`FPRA_SFMT_STOP_LO +: 2] =
						`FPRA_STOP_BITS;
					q_nxt.rsp.prdata[`FPRA_SFMT_PARITY] = 1'b0;
					q_nxt.rsp.prdata[`FPRA_SFMT_SYNC] = 1'b0;
					q_nxt.rsp.prdata[`FPRA_SFMT_DTE] = 1'b1;
				end
				FPRA_REG_NONE: q_nxt.rsp.pslverr = 1'b1;
			endcase
		end
		else if (q_r.rsp.pready)
		begin
			q_nxt.rsp.pready = 1'b0;
			q_nxt.rsp.pslverr = 1'b0;
			// Writes land on the edge that completes the transfer
			if (apb_req.psel && apb_req.penable && apb_req.pwrite)
			begin
				unique case (decode(apb_req.paddr))
					FPRA_REG_CTRL:
					begin
						q_nxt.irq_en = apb_req.pwdata[`FPRA_CTRL_EN];
						q_nxt.irq_lvl = apb_req.pwdata[
							`FPRA_CTRL_LVL_HI:`FPRA_CTRL_LVL_LO];
						q_nxt.hold = apb_req.pwdata[`FPRA_CTRL_HOLD];
						q_nxt.sys_req = apb_req.pwdata[`FPRA_CTRL_SYSRST];
					end
					FPRA_REG_STAT:
						if (apb_req.pwdata[`FPRA_STAT_PEND])
							q_nxt.pend = 1'b0;
					FPRA_REG_SFMT:
						q_nxt.baud = apb_req.pwdata[`FPRA_SFMT_DIV_HI:0];
					FPRA_REG_NONE: ;
				endcase
			end
		end

		// edge sets pending; set beats clear
		if (abt_rise && q_r.irq_en)
			q_nxt.pend = 1'b1;
		q_nxt.irq_n = !(q_r.pend && q_r.irq_en);
		q_nxt.hrst_n = !in_reset;
		q_nxt.brd_n = !in_reset;
		// drive only while stretched controller reset runs
		q_nxt.sys_oe = sys_act;
		q_nxt.lamps.board_failure_lamp = !q_r.s2[`FPRA_PIN_BFAIL];
		q_nxt.lamps.cpu_lamp = !q_r.s2[`FPRA_PIN_DBB];
		q_nxt.lamps.slot_one_activity_lamp = !q_r.s2[`FPRA_PIN_GNT1]
			| (q_r.s2[`FPRA_PIN_CARRIER] & in_reset);
		q_nxt.lamps.slot_two_activity_lamp = !q_r.s2[`FPRA_PIN_GNT2]
			| (q_r.s2[`FPRA_PIN_CARRIER] & in_reset);

		// Synchronisers run through reset, so the strap is settled
		// by the power-up cycle and the controller reset can follow
		rst_ld = RST_ST;
		rst_ld.s1 = q_nxt.s1;
		rst_ld.s2 = q_nxt.s2;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
			q_r <= rst_ld;
		else
			q_r <= q_nxt;
	end

	assign apb_rsp = q_r.rsp;
	assign abort_irq8_n = q_r.irq_n;
	assign abort_irq_level = q_r.irq_lvl;
	assign processor_hard_reset_n = q_r.hrst_n;
	assign board_reset_n = q_r.brd_n;
	// Open drain: only ever pulls low
	assign vme_sysreset_out = 1'b0;
	assign vme_sysreset_oe = q_r.sys_oe;
	assign lamps = q_r.lamps;
	assign serial_baud_div = q_r.baud;

	// Checks
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!nrst);

	logic [31:0] oe_run_r;
	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
			oe_run_r <= '0;
		else if (q_r.sys_oe)
			oe_run_r <= oe_run_r + 32'h1;
		else
			oe_run_r <= '0;
	end

	a_abort_pend: assert property (abt_rise && q_r.irq_en
		|=> q_r.pend ##1 !abort_irq8_n)
		else $error("abort press did not raise interrupt");
	a_abort_masked: assert property (!q_r.irq_en |=> abort_irq8_n)
		else $error("abort interrupt while disabled");
	a_button_reset: assert property (rst_rise |-> ##2 !processor_hard_reset_n
		&& !board_reset_n)
		else $error("reset button did not reset board");
	a_sys_gate: assert property ($rose(vme_sysreset_oe)
		|-> $past(q_r.s2[`FPRA_PIN_SYSCTL], 2))
		else $error("system reset driven while not controller");
	a_sys_causes: assert property (sys_trig |-> ##2 vme_sysreset_oe)
		else $error("system reset cause not driven");
	a_sys_hold: assert property ($fell(vme_sysreset_oe)
		|-> oe_run_r >= 32'(SYSRST_CYC))
		else $error("system reset released too early");
	a_board_hold: assert property (q_r.hold |=> !board_reset_n)
		else $error("hold bit did not keep board in reset");
	a_local_any: assert property (loc_trig && !q_r.s2[`FPRA_PIN_SYSCTL]
		|-> ##2 !processor_hard_reset_n)
		else $error("local reset missing without controller");
	a_fail_lamp: assert property ((!board_failure_n) [*3]
		|=> lamps.board_failure_lamp)
		else $error("failure lamp not lit");
	a_carrier_lamps: assert property (q_r.s2[`FPRA_PIN_CARRIER] && in_reset
		|=> lamps.slot_one_activity_lamp
		&& lamps.slot_two_activity_lamp)
		else $error("carrier lamps dark in reset");
	a_apb_wait: assert property (apb_req.psel && apb_req.penable
		&& !apb_rsp.pready |=> apb_rsp.pready)
		else $error("apb answer late");

	c_abort: cover property (abt_rise && q_r.irq_en ##2 !abort_irq8_n);
	c_sys_rst: cover property ($fell(vme_sysreset_oe));
	c_apb_err: cover property (apb_rsp.pready && apb_rsp.pslverr);
endmodule

// >>> tb/fpra_panel_model.sv
// Purpose: push-buttons and backplane reset line facing the block
// Assumes: buttons pull their pin low while pressed
// Notes: contacts bounce three times on make and once on break
`timescale 1ns/1ns
module fpra_panel_model (
	input wire logic sys_clk,
	input wire logic vme_sysreset_oe,
	output logic abort_button_n,
	output logic reset_button_n,
	output logic vme_sysreset_in_n
);
	logic [1:0] btn_n = 2'h3;
	logic ext_rst = 1'b0;
	assign abort_button_n = btn_n[0];
	assign reset_button_n = btn_n[1];
	// Line is pulled up, so it only goes low while someone drives it
	assign vme_sysreset_in_n = ~(vme_sysreset_oe | ext_rst);
	task automatic press(input int sel, input int hold);
		for (int i = 0; i < 3; i++)
		begin
			@(posedge sys_clk) btn_n[sel] <= 1'b0;
			@(posedge sys_clk) btn_n[sel] <= 1'b1;
		end
		@(posedge sys_clk) btn_n[sel] <= 1'b0;
		repeat (hold) @(posedge sys_clk);
		@(posedge sys_clk) btn_n[sel] <= 1'b1;
		@(posedge sys_clk) btn_n[sel] <= 1'b0;
		@(posedge sys_clk) btn_n[sel] <= 1'b1;
	endtask
	task automatic other_board(input logic v);
		@(posedge sys_clk) ext_rst <= v;
	endtask
endmodule

// >>> tb/fpra_top_test.sv
// Purpose: self-checking bench for the front panel block
// Assumes: short filter and hold counts so the run stays brief
// Notes: expectations are queued by the driver and taken by a monitor
`timescale 1ns/1ns
module fpra_top_test;
	import fpra_pkg::*;
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	fpra_apb_req_t req = '0;
	fpra_apb_rsp_t rsp;
	logic wdog = 1'b0;
	logic sc = 1'b1;
	logic car = 1'b0;
	logic [3:0] lin_n = 4'hF;
	logic ab_n, rb_n, vin_n, irq_n, hr_n, br_n, oe, odat;
	logic [2:0] lvl;
	fpra_lamps_t lmp;
	logic [15:0] baud;
	logic [32:0] q[$];
	int mismatches = 0;
	int samples_checked = 0;
	int cyc = 0;
	logic snap_r = 1'b0;
	logic [31:0] rnd = 32'h1243;
	logic [2:0] lvl_e = 3'h0;
	logic [15:0] baud_e = 16'h0041;
	always #50 sys_clk = ~sys_clk;
	fpra_top #(.DEB_CYC(4), .SYSRST_CYC(20), .LOCRST_CYC(16)) uut (
		.sys_clk(sys_clk), .nrst(nrst), .apb_req(req), .apb_rsp(rsp),
		.abort_button_n(ab_n), .reset_button_n(rb_n),
		.watchdog_timeout(wdog), .vme_sysreset_in_n(vin_n),
		.system_controller(sc), .expansion_carrier(car),
		.board_failure_n(lin_n[3]), .processor_data_bus_busy_n(lin_n[2]),
		.pci_gnt1_n(lin_n[1]), .pci_gnt2_n(lin_n[0]),
		.abort_irq8_n(irq_n), .abort_irq_level(lvl),
		.processor_hard_reset_n(hr_n), .board_reset_n(br_n),
		.vme_sysreset_out(odat), .vme_sysreset_oe(oe), .lamps(lmp),
		.serial_baud_div(baud));
	fpra_panel_model pm (.sys_clk(sys_clk), .vme_sysreset_oe(oe),
		.abort_button_n(ab_n), .reset_button_n(rb_n),
		.vme_sysreset_in_n(vin_n));
	function automatic void xs();
		rnd = rnd ^ (rnd << 13);
		rnd = rnd ^ (rnd >> 17);
		rnd = rnd ^ (rnd << 5);
	endfunction
	// Slot lamps are forced on only on the carrier while in reset
	function automatic logic [32:0] pv(input logic i_n, input logic r_n,
		input logic o);
		logic s;
		s = car & ~r_n;
		return {6'h00, lvl_e, i_n, r_n, r_n, o, ~lin_n[3], ~lin_n[2],
			~lin_n[1] | s, ~lin_n[0] | s, baud_e};
	endfunction
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [32:0] e);
		@(posedge sys_clk);
		if (!w)
			q.push_back(e);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge sys_clk);
		req.penable <= 1'b1;
		do
			@(posedge sys_clk);
		while (rsp.pready !== 1'b1);
		req <= '0;
	endtask
	task automatic snap(input logic [32:0] e);
		@(posedge sys_clk);
		q.push_back(e);
		snap_r <= 1'b1;
		@(posedge sys_clk);
		snap_r <= 1'b0;
	endtask
	task automatic stop_test();
		if (mismatches == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	always @(posedge sys_clk)
	begin
		logic [32:0] obs;
		logic [32:0] e;
		logic go;
		go = 1'b1;
		if (rsp.pready === 1'b1 && req.pwrite === 1'b0)
			obs = {rsp.pslverr, rsp.prdata};
		else if (snap_r)
			obs = {5'h00, odat, lvl, irq_n, hr_n, br_n, oe, lmp, baud};
		else
			go = 1'b0;
		if (go)
		begin
			e = (q.size() != 0) ? q.pop_front() : 'x;
			samples_checked++;
			if (e !== obs)
			begin
				mismatches++;
				$display("mismatch at %0t: expected %h got %h", $time, e, obs);
			end
		end
	end
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 6000)
		begin
			mismatches++;
			stop_test();
		end
	end
	initial
	begin
		repeat (16) @(posedge sys_clk);
		nrst <= 1'b1;
		repeat (3) @(posedge sys_clk);
		snap(pv(1'b1, 1'b0, 1'b1));
		repeat (13) @(posedge sys_clk);
		snap(pv(1'b1, 1'b0, 1'b1));
		repeat (60) @(posedge sys_clk);
		apb(1'b0, 8'h08, 32'h0, 33'h0_0118_0041);
		xs();
		baud_e = rnd[15:0] | 16'h0001;
		apb(1'b1, 8'h08, {rnd[31:16], baud_e}, '0);
		apb(1'b0, 8'h08, 32'h0, {17'h0_0118, baud_e});
		apb(1'b0, 8'h0C, 32'h0, {1'b1, 32'h0});
		for (int i = 0; i < 6; i++)
		begin
			xs();
			lin_n <= rnd[3:0];
			repeat (4) @(posedge sys_clk);
			snap(pv(1'b1, 1'b1, 1'b0));
		end
		lvl_e = 3'h5;
		apb(1'b1, 8'h00, 32'h0000_000B, '0);
		fork
			pm.press(0, 44);
			begin
				repeat (22) @(posedge sys_clk);
				snap(pv(1'b0, 1'b1, 1'b0));
				apb(1'b0, 8'h04, 32'h0, 33'h7);
				apb(1'b1, 8'h04, 32'h2, '0);
			end
		join
		repeat (12) @(posedge sys_clk);
		apb(1'b0, 8'h04, 32'h0, 33'h4);
		snap(pv(1'b1, 1'b1, 1'b0));
		lvl_e = 3'h0;
		apb(1'b1, 8'h00, 32'h0, '0);
		pm.press(0, 20);
		repeat (10) @(posedge sys_clk);
		apb(1'b0, 8'h04, 32'h0, 33'h4);
		// Causes: button as controller, button not, watchdog, other board, software
		for (int k = 0; k < 5; k++)
		begin
			sc <= (k != 1 && k != 3);
			repeat (4) @(posedge sys_clk);
			fork
				case (k)
					0, 1: pm.press(1, 30);
					2: wdog <= 1'b1;
					3: pm.other_board(1'b1);
					default: apb(1'b1, 8'h00, 32'h10, '0);
				endcase
				begin
					repeat ((k == 4) ? 6 : 24) @(posedge sys_clk);
					snap(pv(1'b1, 1'b0, sc));
				end
			join
			wdog <= 1'b0;
			pm.other_board(1'b0);
			repeat (80) @(posedge sys_clk);
			snap(pv(1'b1, 1'b1, 1'b0));
		end
		car <= 1'b1;
		sc <= 1'b0;
		apb(1'b1, 8'h00, 32'h20, '0);
		repeat (40) @(posedge sys_clk);
		snap(pv(1'b1, 1'b0, 1'b0));
		apb(1'b1, 8'h00, 32'h0, '0);
		repeat (40) @(posedge sys_clk);
		snap(pv(1'b1, 1'b1, 1'b0));
		stop_test();
	end
endmodule
